// file: bench/pie_cpu_model.sv
/* processor core model: machine-cycle and instruction-start strobes and
   one-clock vector acknowledge of an offer while the bench allows it. */
`timescale 1ns/10ps
`default_nettype none
module pie_cpu_model (
    input wire logic i_sys_clk, // system clock
    input wire logic i_rst_b, // synchronous reset, active low
    input wire logic i_irq_req, // offer from the controller
    input wire logic i_ack_on, // bench lets the core accept
    output logic o_machine_cycle, // pin sampling strobe
    output logic o_instr_start, // arbitration strobe
    output logic o_vector_ack // acceptance pulse
);
    logic [1:0] cnt_ff;
    always @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            cnt_ff <= 2'h0;
            o_machine_cycle <= 1'b0;
            o_instr_start <= 1'b0;
            o_vector_ack <= 1'b0;
        end else begin
            cnt_ff <= cnt_ff + 2'h1;
            o_machine_cycle <= (cnt_ff == 2'h3);
            o_instr_start <= cnt_ff[0];
            // acknowledge only a standing offer, never twice in a row
            o_vector_ack <= i_ack_on && i_irq_req && !o_vector_ack;
        end
    end
endmodule // pie_cpu_model
`default_nettype wire

// file: bench/pie_ctrl_monitor.sv
/* port checker of pie_ctrl: offers, nesting, external flags, wake.
   assumes it is bound to the pie_ctrl top by the testbench top file. */
`timescale 1ns/10ps
`default_nettype none
module pie_ctrl_monitor (
    input wire logic i_sys_clk, i_rst_b, // clock, synchronous reset
    input wire logic [7:0] i_irq_enable_reg_a, // global and slot enables
    input wire logic i_ext0_trigger_type, i_ext1_trigger_type, // trigger modes
    input wire logic i_ext_irq_pin_0, i_ext_irq_pin_1, // external pins
    input wire logic i_machine_cycle, i_instr_start, i_vector_ack, i_service_done, // core strobes
    input wire logic i_power_down_mode, // low-power state
    input wire logic o_irq_req_ff, o_ext0_request_flag, o_ext1_request_flag, o_wakeup_ff, // outputs
    input wire logic [1:0] o_irq_level_ff, // offered level
    input wire logic [3:0] o_irq_src_ff, o_in_service_ff // offered slot, levels in service
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_b);
    logic smp1_ff; // last strobed sample of pin 1
    always @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            smp1_ff <= 1'b1;
        end else if (i_machine_cycle) begin
            smp1_ff <= i_ext_irq_pin_1;
        end
    end
    sequence take_s;
        o_irq_req_ff && i_vector_ack;
    endsequence
    sequence fall1_s;
        i_machine_cycle && smp1_ff && !i_ext_irq_pin_1 && i_ext1_trigger_type;
    endsequence
    sequence lvl0_s;
        (i_machine_cycle && !i_ext0_trigger_type) ##1 (!i_ext0_trigger_type && $stable(i_ext_irq_pin_0))[*2];
    endsequence
    ack_nest_a: assert property (take_s |=> o_in_service_ff[$past(o_irq_level_ff)] && !o_irq_req_ff)
        else $error("accepted level not marked in service");
    offer_above_a: assert property (o_irq_req_ff |-> (o_in_service_ff >> o_irq_level_ff) == 4'h0)
        else $error("offer not above running level");
    top_hold_a: assert property (o_in_service_ff[3] |-> !o_irq_req_ff)
        else $error("offer while top level in service");
    done_pop_a: assert property (i_service_done && !i_vector_ack && o_in_service_ff[3]
        |=> o_in_service_ff == ($past(o_in_service_ff) & 4'h7)) else $error("service end cleared wrong level");
    gate_off_a: assert property (i_instr_start && !i_vector_ack && !i_irq_enable_reg_a[7] |=> !o_irq_req_ff)
        else $error("offer without global enable");
    level_track_a: assert property (lvl0_s |-> o_ext0_request_flag == !i_ext_irq_pin_0)
        else $error("level flag not tracking pin");
    edge_set_a: assert property (fall1_s |-> ##[1:2] o_ext1_request_flag)
        else $error("falling edge not flagged");
    edge_clr_a: assert property (take_s ##0 (o_irq_src_ff == 4'h2 && i_ext1_trigger_type
        && !(i_machine_cycle && smp1_ff && !i_ext_irq_pin_1)) |=> !o_ext1_request_flag)
        else $error("edge flag kept");
    pd_edge_a: assert property ((i_power_down_mode && i_ext0_trigger_type && i_ext1_trigger_type)[*3]
        |-> !o_wakeup_ff) else $error("edge input woke power-down");
    pd_wake_a: assert property ((i_power_down_mode && !i_ext0_trigger_type && !i_ext_irq_pin_0
        && i_irq_enable_reg_a[7] && i_irq_enable_reg_a[0])[*3] |-> o_wakeup_ff) else $error("no level wake");
endmodule // pie_ctrl_monitor
`default_nettype wire

// file: bench/pie_ctrl_tb.sv
/* self-checking bench of pie_ctrl: gating, levels, polling, nesting,
   external inputs and wake. assumes pie_cpu_model plays the core. */
`timescale 1ns/10ps
`default_nettype none
module pie_ctrl_tb;
    logic i_sys_clk = 1'b0;
    logic i_rst_b = 1'b0;
    logic [14:0] en = 15'h0, plo = 15'h0, phi = 15'h0, flags = 15'h0;
    logic gen = 1'b0, trig0 = 1'b0, trig1 = 1'b0, pin0 = 1'b1, pin1 = 1'b1;
    logic done = 1'b0, idle = 1'b0, pd = 1'b0, ack_on = 1'b0;
    logic [1:0] fclr = 2'h0;
    wire mc, is, ack, req, f0, f1, wake;
    wire [3:0] src, insvc;
    wire [1:0] lvl;
    int errors = 0, num_checks = 0;
    logic [3:0] ord [13] = '{4'h5, 4'h6, 4'h1, 4'h7, 4'hB, 4'h8, 4'hC, 4'h3, 4'h9, 4'hD, 4'h4, 4'hA, 4'hE};
    always #4 i_sys_clk = ~i_sys_clk;
    pie_ctrl pie_ctrl_i (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_irq_enable_reg_a({gen, en[6:0]}),
        .i_irq_enable_reg_b(en[14:7]), .i_priority_low_bits_a({1'b0, plo[6:0]}),
        .i_priority_high_bits_a({1'b0, phi[6:0]}), .i_priority_low_bits_b(plo[14:7]),
        .i_priority_high_bits_b(phi[14:7]), .i_ext0_trigger_type(trig0), .i_ext1_trigger_type(trig1),
        .i_ext_irq_pin_0(pin0), .i_ext_irq_pin_1(pin1), .i_src_flags(flags), .i_ext_flag_clr(fclr),
        .i_machine_cycle(mc), .i_instr_start(is), .i_vector_ack(ack), .i_service_done(done),
        .i_idle_mode(idle), .i_power_down_mode(pd), .o_irq_req_ff(req), .o_irq_src_ff(src),
        .o_irq_level_ff(lvl), .o_in_service_ff(insvc), .o_ext0_request_flag(f0),
        .o_ext1_request_flag(f1), .o_wakeup_ff(wake));
    pie_cpu_model pie_cpu_model_i (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_irq_req(req),
        .i_ack_on(ack_on), .o_machine_cycle(mc), .o_instr_start(is), .o_vector_ack(ack));
    task automatic test_done;
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge i_sys_clk);
    endtask
    // settled sample of one output bit, then back on a rising edge
    task automatic look(input int n, input logic seen_sel, input logic exp);
        cyc(n);
        @(negedge i_sys_clk);
        chk({7'h0, seen_sel ? wake : req}, {7'h0, exp});
        @(posedge i_sys_clk);
    endtask
    task automatic wait_req(input logic v);
        int k;
        k = 0;
        @(negedge i_sys_clk);
        while (req !== v && k < 40) begin
            @(negedge i_sys_clk);
            k++;
        end
        if (req !== v) begin
            errors++;
            $display("[FAIL] %0t offer wait ran out", $time);
            test_done();
        end
    endtask
    task automatic set_src(input logic [3:0] s, input logic [1:0] l);
        en[s] <= 1'b1;
        flags[s] <= 1'b1;
        phi[s] <= l[1];
        plo[s] <= l[0];
    endtask
    task automatic serve(input logic [3:0] s, input logic [1:0] l);
        cyc(4);
        wait_req(1'b1);
        chk({4'h0, src}, {4'h0, s});
        chk({6'h0, lvl}, {6'h0, l});
        @(posedge i_sys_clk) ack_on <= 1'b1;
        wait_req(1'b0);
        chk({7'h0, insvc[l]}, 8'h1);
        @(posedge i_sys_clk) ack_on <= 1'b0;
        flags[s] <= 1'b0;
    endtask
    task automatic pop(input logic [3:0] exp);
        @(posedge i_sys_clk) done <= 1'b1;
        @(posedge i_sys_clk) done <= 1'b0;
        @(negedge i_sys_clk);
        chk({4'h0, insvc}, {4'h0, exp});
        @(posedge i_sys_clk);
    endtask
    task automatic tend(input string nm);
        $display("%s finished, mismatches so far %0d", nm, errors);
    endtask
    initial begin
        cyc(4);
        i_rst_b <= 1'b1;
        set_src(4'h1, 2'h0);
        look(10, 1'b0, 1'b0);
        gen <= 1'b1;
        serve(4'h1, 2'h0);
        pop(4'h0);
        tend("gating");
        for (int l = 0; l < 4; l++) begin
            set_src(4'h1, l[1:0]);
            set_src(4'h7, 2'h1);
            if (l == 0) serve(4'h7, 2'h1); else serve(4'h1, l[1:0]);
            pop(4'h0);
        end
        flags <= 15'h0;
        for (int k = 0; k < 13; k++) set_src(ord[k], 2'h2);
        for (int k = 0; k < 13; k++) begin
            serve(ord[k], 2'h2);
            pop(4'h0);
        end
        tend("levels");
        set_src(4'h1, 2'h1);
        set_src(4'h7, 2'h1);
        serve(4'h1, 2'h1);
        look(8, 1'b0, 1'b0);
        set_src(4'h3, 2'h3);
        serve(4'h3, 2'h3);
        set_src(4'hA, 2'h3);
        look(8, 1'b0, 1'b0);
        pop(4'h2);
        serve(4'hA, 2'h3);
        pop(4'h2);
        pop(4'h0);
        serve(4'h7, 2'h1);
        pop(4'h0);
        tend("nesting");
        en[0] <= 1'b1;
        phi[0] <= 1'b1;
        pin0 <= 1'b0; // held low through two services
        serve(4'h0, 2'h2);
        @(negedge i_sys_clk) chk({7'h0, f0}, 8'h1);
        pop(4'h0);
        serve(4'h0, 2'h2);
        pin0 <= 1'b1;
        cyc(10);
        @(negedge i_sys_clk) chk({7'h0, f0}, 8'h0);
        pop(4'h0);
        en[0] <= 1'b0;
        trig1 <= 1'b1;
        set_src(4'h2, 2'h1);
        cyc(8);
        pin1 <= 1'b0; // high, then low and kept low through the service
        serve(4'h2, 2'h1);
        @(negedge i_sys_clk) chk({7'h0, f1}, 8'h0);
        pop(4'h0);
        look(8, 1'b0, 1'b0);
        pin1 <= 1'b1;
        cyc(8);
        pin1 <= 1'b0;
        cyc(10);
        @(negedge i_sys_clk) chk({7'h0, f1}, 8'h1);
        @(posedge i_sys_clk) fclr <= 2'h2;
        @(posedge i_sys_clk) fclr <= 2'h0;
        cyc(2);
        @(negedge i_sys_clk) chk({7'h0, f1}, 8'h0);
        @(posedge i_sys_clk) en[2] <= 1'b0;
        tend("external");
        pd <= 1'b1;
        trig0 <= 1'b1;
        en[0] <= 1'b1;
        pin0 <= 1'b0;
        look(8, 1'b1, 1'b0);
        trig0 <= 1'b0;
        look(4, 1'b1, 1'b1);
        pd <= 1'b0;
        idle <= 1'b1;
        look(4, 1'b1, 1'b1);
        idle <= 1'b0;
        look(4, 1'b1, 1'b0);
        pin0 <= 1'b1;
        flags[5] <= 1'b1;
        pd <= 1'b1;
        look(8, 1'b1, 1'b0);
        pd <= 1'b0;
        idle <= 1'b1;
        look(4, 1'b1, 1'b1);
        idle <= 1'b0;
        tend("wake");
        test_done();
    end
endmodule // pie_ctrl_tb
bind pie_ctrl pie_ctrl_monitor pie_ctrl_monitor_i (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b),
    .i_irq_enable_reg_a(i_irq_enable_reg_a), .i_ext0_trigger_type(i_ext0_trigger_type),
    .i_ext1_trigger_type(i_ext1_trigger_type), .i_ext_irq_pin_0(i_ext_irq_pin_0),
    .i_ext_irq_pin_1(i_ext_irq_pin_1), .i_machine_cycle(i_machine_cycle), .i_instr_start(i_instr_start),
    .i_vector_ack(i_vector_ack), .i_service_done(i_service_done), .i_power_down_mode(i_power_down_mode),
    .o_irq_req_ff(o_irq_req_ff), .o_ext0_request_flag(o_ext0_request_flag),
    .o_ext1_request_flag(o_ext1_request_flag), .o_wakeup_ff(o_wakeup_ff), .o_irq_level_ff(o_irq_level_ff),
    .o_irq_src_ff(o_irq_src_ff), .o_in_service_ff(o_in_service_ff));
`default_nettype wire

// file: design/pie_arbiter.v
/*
 * Combinational arbiter: picks the pending, enabled source with the
 * highest level above the running service level; equal levels are
 * resolved by the fixed polling rank.
 * Assumes the caller registers the result at an instruction start.
 */
`timescale 1ns/10ps
`default_nettype none
`include "pie_regs.vh"

module pie_arbiter (
    input wire [14:0] i_pend,     // pending and enabled sources
    input wire [14:0] i_prio_hi,  // priority high bit per source
    input wire [14:0] i_prio_lo,  // priority low bit per source
    input wire i_busy,            // a service routine is running
    input wire [1:0] i_cur_lvl,   // level of the running service
    output reg o_win_valid,       // a source may be taken
    output reg [3:0] o_win_src,   // winning source slot
    output reg [1:0] o_win_lvl    // level of the winner
);

    localparam [59:0] RANKS = `PIE_RANK_TABLE;

    wire [1:0] lvl [0:14];
    wire [14:0] elig;
    reg [3:0] best_rank;
    integer i;

    genvar g;
    generate
        for (g = 0; g < `PIE_NUM_SRC; g = g + 1) begin : g_src
            assign lvl[g] = {i_prio_hi[g], i_prio_lo[g]}; // see RL3
            // strictly above the running level, so top level blocks all
            assign elig[g] = i_pend[g] & (~i_busy | (lvl[g] > i_cur_lvl)); // see RL4 see RL5
        end
    endgenerate

    always @* begin
        o_win_valid = 1'b0;
        o_win_src = `PIE_RST_SRC;
        o_win_lvl = `PIE_RST_LVL;
        best_rank = `PIE_RANK_NONE;
        for (i = 0; i < `PIE_NUM_SRC; i = i + 1) begin
            if (elig[i] && (!o_win_valid || lvl[i] > o_win_lvl ||                  // see RL6
                (lvl[i] == o_win_lvl && RANKS[i*4 +: 4] < best_rank))) begin       // see RL7
                o_win_valid = 1'b1;
                o_win_src = i[3:0];
                o_win_lvl = lvl[i];
                best_rank = RANKS[i*4 +: 4];
            end
        end
    end

endmodule // pie_arbiter

`default_nettype wire

// file: design/pie_ctrl.v
/*
 * Priority interrupt controller top: enable gating, four-level priority
 * with nesting, same-level polling, two external inputs and wake-up.
 * Assumes one synchronous clock, peripheral flags held until serviced,
 * and a processor that acknowledges a request with a one-clock vector
 * pulse and reports each routine's end with a one-clock done pulse.
 */
// Function
// RL1: fifteen sources, each placed at one of four levels, 0 lowest to 3 highest.
// RL2: a source is taken only with its own enable and the global enable set.
// RL3: priority high and low bit form the level; 00 lowest, 11 highest.
// RL4: running service preempted only by strictly higher priority; others wait.
// RL5: service at top level is never preempted.
// RL6: simultaneous requests of different levels: higher level served first.
// RL7: equal-level pending requests resolved by fixed polling order at instruction start.
// RL8: level mode: low level on external pin requests an interrupt.
// RL9: edge mode: flag set when a high sample is followed by a low sample.
// RL10: each external pin sampled exactly once per machine cycle.
// RL11: requester holds pin high one machine cycle, then low one, for edges.
// RL12: edge mode flag cleared automatically when the processor vectors to it.
// RL13: level mode requester holds pin asserted until the interrupt is generated.
// RL14: level mode pin still low after service end raises another interrupt.
// RL15: level mode flag tracks the pin; software need not clear it.
// RL16: enabled level-mode external input wakes the device from idle or power-down.
// RL17: only level-mode external inputs wake from power-down, edge mode does not.
// RL18: a blocked request stays pending until serviced or cleared by software.
`timescale 1ns/10ps
`default_nettype none
`include "pie_regs.vh"

module pie_ctrl (
    input wire i_sys_clk,                    // 125 MHz system clock
    input wire i_rst_b,                      // synchronous reset, active low
    input wire [7:0] i_irq_enable_reg_a,     // bit 7 global enable, 6..0 slot enables
    input wire [7:0] i_irq_enable_reg_b,     // enables of slots 7..14
    input wire [7:0] i_priority_low_bits_a,  // priority low bits, slots 0..6
    input wire [7:0] i_priority_high_bits_a, // priority high bits, slots 0..6
    input wire [7:0] i_priority_low_bits_b,  // priority low bits, slots 7..14
    input wire [7:0] i_priority_high_bits_b, // priority high bits, slots 7..14
    input wire i_ext0_trigger_type,          // 0 level, 1 falling edge
    input wire i_ext1_trigger_type,          // 0 level, 1 falling edge
    input wire i_ext_irq_pin_0,              // external request 0, active low
    input wire i_ext_irq_pin_1,              // external request 1, active low
    input wire [14:0] i_src_flags,           // peripheral flags; slots 0 and 2 unused
    input wire [1:0] i_ext_flag_clr,         // software clear of external flags
    input wire i_machine_cycle,              // one pulse per machine cycle
    input wire i_instr_start,                // pulse at each instruction start
    input wire i_vector_ack,                 // processor vectors to the offered source
    input wire i_service_done,               // running service routine returns
    input wire i_idle_mode,                  // device is in idle
    input wire i_power_down_mode,            // device is in power-down
    output reg o_irq_req_ff,                 // interrupt offered to the processor
    output reg [3:0] o_irq_src_ff,           // slot of the offered source
    output reg [1:0] o_irq_level_ff,         // level of the offered source
    output reg [3:0] o_in_service_ff,        // one bit per level in service
    output wire o_ext0_request_flag,         // external request flag 0
    output wire o_ext1_request_flag,         // external request flag 1
    output reg o_wakeup_ff                   // wake request to power control
);

    wire global_irq_enable;
    wire [14:0] src_enable;
    wire [14:0] prio_hi;
    wire [14:0] prio_lo;
    wire [14:0] src_pend;
    wire [14:0] pend_gated;
    wire ext0_en;
    wire ext1_en;
    wire ext0_wake;
    wire ext1_wake;
    wire ext0_vec_clr;
    wire ext1_vec_clr;
    wire take;
    wire win_valid;
    wire [3:0] win_src;
    wire [1:0] win_lvl;
    reg busy;
    reg [1:0] cur_lvl;
    reg [3:0] top_one_hot;
    reg [3:0] level_one_hot;
    reg nxt_irq_req;
    reg [3:0] nxt_irq_src;
    reg [1:0] nxt_irq_level;
    reg [3:0] nxt_in_service;
    reg nxt_wakeup;

    // gather the two register sets into one slot-indexed vector
    assign global_irq_enable = i_irq_enable_reg_a[`PIE_GLOBAL_EN_BIT];
    assign src_enable = {i_irq_enable_reg_b, i_irq_enable_reg_a[6:0]};
    assign prio_hi = {i_priority_high_bits_b, i_priority_high_bits_a[6:0]};
    assign prio_lo = {i_priority_low_bits_b, i_priority_low_bits_a[6:0]};

    // the external slots come from the local flag logic
    assign src_pend = {i_src_flags[14:3], o_ext1_request_flag, i_src_flags[1], o_ext0_request_flag};

    // disabled sources keep their flags, they are only hidden here
    assign pend_gated = src_pend & src_enable & {15{global_irq_enable}}; // see RL1 see RL2

    assign ext0_en = global_irq_enable & src_enable[0];
    assign ext1_en = global_irq_enable & src_enable[2];

    // acceptance of the offered request by the processor
    assign take = o_irq_req_ff & i_vector_ack;
    assign ext0_vec_clr = take & (o_irq_src_ff == `PIE_SRC_EXT0); // see RL12
    assign ext1_vec_clr = take & (o_irq_src_ff == `PIE_SRC_EXT1); // see RL12

    pie_ext_irq u_ext0 (
        .i_sys_clk(i_sys_clk),
        .i_rst_b(i_rst_b),
        .i_machine_cycle(i_machine_cycle),
        .i_pin(i_ext_irq_pin_0),
        .i_trigger_type(i_ext0_trigger_type),
        .i_enabled(ext0_en),
        .i_vector_clr(ext0_vec_clr),
        .i_sw_clr(i_ext_flag_clr[0]),
        .o_flag_ff(o_ext0_request_flag),
        .o_wake_ff(ext0_wake)
    );

    pie_ext_irq u_ext1 (
        .i_sys_clk(i_sys_clk),
        .i_rst_b(i_rst_b),
        .i_machine_cycle(i_machine_cycle),
        .i_pin(i_ext_irq_pin_1),
        .i_trigger_type(i_ext1_trigger_type),
        .i_enabled(ext1_en),
        .i_vector_clr(ext1_vec_clr),
        .i_sw_clr(i_ext_flag_clr[1]),
        .o_flag_ff(o_ext1_request_flag),
        .o_wake_ff(ext1_wake)
    );

    // running level is the highest level in service
    always @* begin
        busy = |o_in_service_ff;
        case (1'b1)
            o_in_service_ff[3]: begin
                cur_lvl = 2'h3;
                top_one_hot = 4'h8;
            end
            o_in_service_ff[2]: begin
                cur_lvl = 2'h2;
                top_one_hot = 4'h4;
            end
            o_in_service_ff[1]: begin
                cur_lvl = 2'h1;
                top_one_hot = 4'h2;
            end
            o_in_service_ff[0]: begin
                cur_lvl = 2'h0;
                top_one_hot = 4'h1;
            end
            default: begin
                cur_lvl = 2'h0;
                top_one_hot = 4'h0;
            end
        endcase
    end

    pie_arbiter u_arb (
        .i_pend(pend_gated),
        .i_prio_hi(prio_hi),
        .i_prio_lo(prio_lo),
        .i_busy(busy),
        .i_cur_lvl(cur_lvl),
        .o_win_valid(win_valid),
        .o_win_src(win_src),
        .o_win_lvl(win_lvl)
    );

    always @* begin
        case (o_irq_level_ff)
            2'h0: level_one_hot = 4'h1;
            2'h1: level_one_hot = 4'h2;
            2'h2: level_one_hot = 4'h4;
            2'h3: level_one_hot = 4'h8;
            default: level_one_hot = 4'h0;
        endcase
    end

    // offer to the processor: polled only at instruction starts, dropped
    // when taken; an acceptance in the same cycle as an instruction start
    // wins so the taken source is not offered twice
    always @* begin
        nxt_irq_req = o_irq_req_ff;
        nxt_irq_src = o_irq_src_ff;
        nxt_irq_level = o_irq_level_ff;
        if (take) begin
            nxt_irq_req = 1'b0;
        end else if (i_instr_start) begin
            nxt_irq_req = win_valid; // see RL4 see RL6 see RL7
            nxt_irq_src = win_src;
            nxt_irq_level = win_lvl;
        end
    end

    // in-service bits give nesting; the end of a routine retires the
    // highest level, after which a still-low level-mode pin is polled again
    always @* begin
        nxt_in_service = o_in_service_ff;
        if (i_service_done) begin
            nxt_in_service = nxt_in_service & ~top_one_hot; // see RL14
        end
        if (take) begin
            nxt_in_service = nxt_in_service | level_one_hot; // see RL5
        end
    end

    // idle: any enabled request wakes; power-down: level-mode externals only
    always @* begin
        nxt_wakeup = 1'b0;
        if (i_power_down_mode) begin
            nxt_wakeup = ext0_wake | ext1_wake; // see RL17
        end else if (i_idle_mode) begin
            nxt_wakeup = ext0_wake | ext1_wake | (|pend_gated); // see RL16
        end
    end

    always @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            o_irq_req_ff <= `PIE_RST_REQ;
            o_irq_src_ff <= `PIE_RST_SRC;
            o_irq_level_ff <= `PIE_RST_LVL;
            o_in_service_ff <= `PIE_RST_INSVC;
            o_wakeup_ff <= 1'b0;
        end else begin
            o_irq_req_ff <= nxt_irq_req;
            o_irq_src_ff <= nxt_irq_src;
            o_irq_level_ff <= nxt_irq_level;
            o_in_service_ff <= nxt_in_service;
            o_wakeup_ff <= nxt_wakeup;
        end
    end

endmodule // pie_ctrl

`default_nettype wire

// file: design/pie_ext_irq.v
/*
 * One external interrupt input: samples the pin once per machine cycle,
 * produces the request flag in level or falling-edge mode, and a
 * power-down wake request for level mode.
 * Assumes the pin is synchronous to i_sys_clk and i_machine_cycle is a
 * one-clock pulse per machine cycle.
 */
`timescale 1ns/10ps
`default_nettype none
`include "pie_regs.vh"

module pie_ext_irq (
    input wire i_sys_clk,       // system clock
    input wire i_rst_b,         // synchronous reset, active low
    input wire i_machine_cycle, // sampling pulse, once per machine cycle
    input wire i_pin,           // external request pin, active low
    input wire i_trigger_type,  // 0 level, 1 falling edge
    input wire i_enabled,       // source and global enable both set
    input wire i_vector_clr,    // processor vectored to this source
    input wire i_sw_clr,        // software clear of the flag
    output reg o_flag_ff,       // request flag
    output reg o_wake_ff        // level-mode wake request
);

    reg sample_ff;
    reg nxt_flag;
    wire fall_seen;

    // one new sample per machine cycle
    always @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            sample_ff <= `PIE_RST_PIN;
        end else if (i_machine_cycle) begin // see RL10
            sample_ff <= i_pin;
        end
    end

    // high sample followed by low sample
    assign fall_seen = i_machine_cycle & sample_ff & ~i_pin; // see RL9

    always @* begin
        if (!i_trigger_type) begin
            nxt_flag = ~sample_ff; // see RL8 see RL15
        end else if (fall_seen) begin
            nxt_flag = 1'b1; // a new edge beats a clear in the same cycle
        end else if (i_vector_clr | i_sw_clr) begin
            nxt_flag = 1'b0; // see RL12
        end else begin
            nxt_flag = o_flag_ff; // see RL18
        end
    end

    always @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            o_flag_ff <= `PIE_RST_FLAG;
            o_wake_ff <= 1'b0;
        end else begin
            o_flag_ff <= nxt_flag;
            // raw pin: the sampling pulse may be stopped in power-down
            o_wake_ff <= i_enabled & ~i_trigger_type & ~i_pin; // see RL16 see RL17
        end
    end

endmodule // pie_ext_irq

`default_nettype wire

// file: design/pie_regs.vh
/*
 * Constants of the priority interrupt controller: source count, source
 * slots, field positions of the enable and priority inputs, the fixed
 * polling ranks and reset values.
 * Assumes it is included by its bare name from the design files.
 */
`ifndef PIE_REGS_VH
`define PIE_REGS_VH

// fifteen sources, four priority levels
`define PIE_NUM_SRC 15
`define PIE_SRC_W 4
`define PIE_LVL_W 2
`define PIE_NUM_LVL 4
`define PIE_LVL_TOP 2'h3

// source slots: slots 0..6 map to enable/priority set a bits 0..6,
// slots 7..14 map to set b bits 0..7
`define PIE_SRC_EXT0 4'h0
`define PIE_SRC_EXT1 4'h2
`define PIE_SET_A_SLOTS 7

// global enable position inside irq_enable_reg_a
`define PIE_GLOBAL_EN_BIT 7

// polling rank per slot, 4 bits each, slot 0 in the low nibble;
// rank 1 is polled first
`define PIE_RANK_TABLE 60'hFC96EB8532DA741
`define PIE_RANK_NONE 4'hF

// reset values
`define PIE_RST_REQ 1'h0
`define PIE_RST_SRC 4'h0
`define PIE_RST_LVL 2'h0
`define PIE_RST_INSVC 4'h0
`define PIE_RST_PIN 1'h1
`define PIE_RST_FLAG 1'h0

`endif
